// File: logic/ctf_pkg.sv
// Shared constants for the control transport field framer and its receiver
package ctf_pkg;

    // ------------------------------------------------------------
    // Character and length widths
    // ------------------------------------------------------------
    localparam int CTF_CHR_W = 8;
    localparam int CTF_LEN_W = 9;

    // ------------------------------------------------------------
    // Field length limits, in characters
    // ------------------------------------------------------------
    localparam logic [CTF_LEN_W-1:0] CTF_OVERHEAD = 9'h020;
    localparam logic [CTF_LEN_W-1:0] CTF_MAX_LEN = 9'h100;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [CTF_LEN_W-1:0] CTF_LEN_RST = 9'h000;
    localparam logic [CTF_CHR_W-1:0] CTF_CHR_RST = 8'h00;

    // Link mode selection
    typedef enum logic {
        CTF_MODE_SYNC,
        CTF_MODE_ASYNC
    } ctf_mode_e;

    // Legal field or packet length: above overhead, at most the maximum
    function automatic logic ctf_len_ok(input logic [CTF_LEN_W-1:0] len);
        ctf_len_ok = (len > CTF_OVERHEAD) && (len <= CTF_MAX_LEN);
    endfunction : ctf_len_ok

endpackage : ctf_pkg

// File: logic/ctf_link_if.sv
// Character link between the field framer and the field receiver
`timescale 1ns/10ps
interface ctf_link_if;
    import ctf_pkg::*;

    // Character strobe and data
    logic vld;
    logic [CTF_CHR_W-1:0] chr;
    // Field delimiters and padding marker
    logic sof;
    logic eof;
    logic pad;

    modport framer (output vld, output chr, output sof, output eof,
        output pad);
    modport receiver (input vld, input chr, input sof, input eof,
        input pad);
endinterface : ctf_link_if

// File: logic/ctf_receiver.sv
// Far end: takes fields apart, passes packet characters, checks lengths
`timescale 1ns/10ps
module ctf_receiver
    import ctf_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // Configuration
    input wire logic mode_async_i,
    input wire logic [CTF_LEN_W-1:0] field_len_i,
    // Link from the framer
    ctf_link_if.receiver lk,
    // Packet characters out
    output logic pkt_vld_o,
    output logic pkt_first_o,
    output logic [CTF_CHR_W-1:0] pkt_chr_o,
    // Field status
    output logic field_done_o,
    output logic field_err_o,
    output logic pad_seen_o
);

    logic [CTF_LEN_W-1:0] cnt_r, cnt_nxt;
    logic in_pad_r, in_pad_nxt;
    logic bad_r, bad_nxt;
    logic pkt_vld_nxt, pkt_first_nxt, done_nxt, err_nxt, pseen_nxt;
    logic [CTF_CHR_W-1:0] pkt_chr_nxt;
    logic [CTF_LEN_W-1:0] total;

    // ------------------------------------------------------------
    // Field tracking and checks
    // ------------------------------------------------------------
    always_comb begin
        cnt_nxt = cnt_r;
        in_pad_nxt = in_pad_r;
        bad_nxt = bad_r;
        pkt_vld_nxt = 1'b0;
        pkt_first_nxt = 1'b0;
        pkt_chr_nxt = pkt_chr_o;
        done_nxt = 1'b0;
        err_nxt = 1'b0;
        pseen_nxt = 1'b0;
        total = cnt_r + 9'h001;
        if (lk.vld) begin
            // Start marker must open the field, and only there
            if (lk.sof != (cnt_r == CTF_LEN_RST)) begin
                bad_nxt = 1'b1;
            end
            if (lk.pad) begin
                in_pad_nxt = 1'b1;
                pseen_nxt = mode_async_i;
            end else if (in_pad_r) begin
                bad_nxt = 1'b1;
            end else begin
                pkt_vld_nxt = 1'b1;
                pkt_first_nxt = (cnt_r == CTF_LEN_RST);
                pkt_chr_nxt = lk.chr;
            end
            cnt_nxt = total;
            if (lk.eof) begin
                done_nxt = 1'b1;
                err_nxt = bad_nxt || !ctf_len_ok(total);
                if (!mode_async_i && total != field_len_i) begin
                    err_nxt = 1'b1;
                end
                cnt_nxt = CTF_LEN_RST;
                in_pad_nxt = 1'b0;
                bad_nxt = 1'b0;
            end else if (total >= CTF_MAX_LEN) begin
                bad_nxt = 1'b1;
            end
        end
    end

    // Registers
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            cnt_r <= CTF_LEN_RST;
            in_pad_r <= 1'b0;
            bad_r <= 1'b0;
            pkt_vld_o <= 1'b0;
            pkt_first_o <= 1'b0;
            pkt_chr_o <= CTF_CHR_RST;
            field_done_o <= 1'b0;
            field_err_o <= 1'b0;
            pad_seen_o <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            in_pad_r <= in_pad_nxt;
            bad_r <= bad_nxt;
            pkt_vld_o <= pkt_vld_nxt;
            pkt_first_o <= pkt_first_nxt;
            pkt_chr_o <= pkt_chr_nxt;
            field_done_o <= done_nxt;
            field_err_o <= err_nxt;
            pad_seen_o <= pseen_nxt;
        end
    end

endmodule : ctf_receiver

// File: logic/ctf_framer.sv
// Device end: builds each control transport field from a packet, padded to the field length in synchronous mode only
`timescale 1ns/10ps
module ctf_framer
    import ctf_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // Configuration
    input wire logic mode_async_i,
    input wire logic [CTF_LEN_W-1:0] field_len_i,
    input wire logic [CTF_CHR_W-1:0] pad_chr_i,
    // Frame timing, synchronous mode
    input wire logic frame_tick_i,
    // Data link packet characters in
    input wire logic pkt_vld_i,
    input wire logic [CTF_CHR_W-1:0] pkt_chr_i,
    input wire logic [CTF_LEN_W-1:0] pkt_len_i,
    output logic pkt_rdy_o,
    // Status
    output logic busy_o,
    output logic cfg_err_o,
    output logic pkt_err_o,
    output logic tick_miss_o,
    // Link to the receiver
    ctf_link_if.framer lk
);

    typedef enum logic [1:0] {
        CTF_IDLE,
        CTF_SEND,
        CTF_DROP
    } ctf_state_e;

    ctf_state_e st_r, st_nxt;
    logic [CTF_LEN_W-1:0] cnt_r, cnt_nxt;
    logic [CTF_LEN_W-1:0] len_r, len_nxt;
    logic [CTF_LEN_W-1:0] plen_r, plen_nxt;
    logic [CTF_CHR_W-1:0] pad_r, pad_nxt;
    logic take_r, take_nxt;
    logic vld_r, vld_nxt;
    logic [CTF_CHR_W-1:0] chr_r, chr_nxt;
    logic sof_r, sof_nxt;
    logic eof_r, eof_nxt;
    logic padf_r, padf_nxt;
    logic cfg_err_nxt, pkt_err_nxt, miss_nxt;
    logic emit, accept, pkt_fits;

    // ------------------------------------------------------------
    // Field sequencing
    // ------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        len_nxt = len_r;
        plen_nxt = plen_r;
        pad_nxt = pad_r;
        take_nxt = take_r;
        vld_nxt = 1'b0;
        chr_nxt = chr_r;
        sof_nxt = 1'b0;
        eof_nxt = 1'b0;
        padf_nxt = 1'b0;
        pkt_err_nxt = 1'b0;
        miss_nxt = 1'b0;
        emit = 1'b0;
        accept = take_r && pkt_vld_i;
        // Static length check in synchronous mode only
        cfg_err_nxt = !mode_async_i && !ctf_len_ok(field_len_i);
        // A packet fits the field when legal and no longer than the field
        pkt_fits = ctf_len_ok(pkt_len_i) && (pkt_len_i <= field_len_i);
        unique case (st_r)
            CTF_IDLE: begin
                if (mode_async_i) begin
                    // Packet goes out at once in its own-sized field
                    if (pkt_vld_i) begin
                        if (ctf_len_ok(pkt_len_i)) begin
                            st_nxt = CTF_SEND;
                            len_nxt = pkt_len_i;
                        end else begin
                            st_nxt = CTF_DROP;
                            pkt_err_nxt = 1'b1;
                        end
                        plen_nxt = pkt_len_i;
                        take_nxt = 1'b1;
                    end
                end else if (frame_tick_i && !cfg_err_nxt) begin
                    // Length fixed at field start, held for the field
                    st_nxt = CTF_SEND;
                    len_nxt = field_len_i;
                    pad_nxt = pad_chr_i;
                    if (pkt_vld_i && pkt_fits) begin
                        plen_nxt = pkt_len_i;
                        take_nxt = 1'b1;
                    end else begin
                        // No packet, or one that does not fit, which the check below drops
                        take_nxt = 1'b0;
                    end
                end
            end
            CTF_SEND: begin
                if (take_r) begin
                    // Packet characters pass unchanged
                    if (accept) begin
                        emit = 1'b1;
                        chr_nxt = pkt_chr_i;
                        plen_nxt = plen_r - 9'h001;
                        if (plen_r == 9'h001) begin
                            take_nxt = 1'b0;
                        end
                    end
                end else begin
                    // Fill the rest of the field with padding
                    emit = !mode_async_i;
                    chr_nxt = pad_r;
                    // Pad marker only with a strobe, never in async mode
                    padf_nxt = !mode_async_i;
                end
                if (emit) begin
                    vld_nxt = 1'b1;
                    sof_nxt = (cnt_r == CTF_LEN_RST);
                    cnt_nxt = cnt_r + 9'h001;
                    if (cnt_nxt == len_r) begin
                        eof_nxt = 1'b1;
                        cnt_nxt = CTF_LEN_RST;
                        take_nxt = 1'b0;
                        st_nxt = CTF_IDLE;
                    end
                end
                if (!padf_nxt && !emit && mode_async_i && !take_r) begin
                    st_nxt = CTF_IDLE;
                end
            end
            CTF_DROP: begin
                // Discard a packet whose length cannot be framed
                if (accept) begin
                    plen_nxt = plen_r - 9'h001;
                    if (plen_r <= 9'h001) begin
                        take_nxt = 1'b0;
                        st_nxt = CTF_IDLE;
                    end
                end
            end
            default: begin
                st_nxt = CTF_IDLE;
                take_nxt = 1'b0;
            end
        endcase
        // In synchronous mode a packet longer than the field never fits
        if (st_r == CTF_IDLE && !mode_async_i && frame_tick_i
                && !cfg_err_nxt && pkt_vld_i && !pkt_fits) begin
            st_nxt = CTF_DROP;
            plen_nxt = pkt_len_i;
            take_nxt = 1'b1;
            pkt_err_nxt = 1'b1;
        end
        // A frame tick that finds a field in progress is lost
        if (frame_tick_i && !mode_async_i && st_r != CTF_IDLE) begin
            miss_nxt = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            st_r <= CTF_IDLE;
            cnt_r <= CTF_LEN_RST;
            len_r <= CTF_LEN_RST;
            plen_r <= CTF_LEN_RST;
            pad_r <= CTF_CHR_RST;
            take_r <= 1'b0;
            vld_r <= 1'b0;
            chr_r <= CTF_CHR_RST;
            sof_r <= 1'b0;
            eof_r <= 1'b0;
            padf_r <= 1'b0;
            busy_o <= 1'b0;
            cfg_err_o <= 1'b0;
            pkt_err_o <= 1'b0;
            tick_miss_o <= 1'b0;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            len_r <= len_nxt;
            plen_r <= plen_nxt;
            pad_r <= pad_nxt;
            take_r <= take_nxt;
            vld_r <= vld_nxt;
            chr_r <= chr_nxt;
            sof_r <= sof_nxt;
            eof_r <= eof_nxt;
            padf_r <= padf_nxt;
            busy_o <= (st_nxt != CTF_IDLE);
            cfg_err_o <= cfg_err_nxt;
            pkt_err_o <= pkt_err_nxt;
            tick_miss_o <= miss_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs, all straight from flip-flops
    // ------------------------------------------------------------
    assign pkt_rdy_o = take_r;
    assign lk.vld = vld_r;
    assign lk.chr = chr_r;
    assign lk.sof = sof_r;
    assign lk.eof = eof_r;
    assign lk.pad = padf_r;

endmodule : ctf_framer

// File: test/ctf_link_checker.sv
// Checker for the framer to receiver character link
`timescale 1ns/10ps
module ctf_link_checker
    import ctf_pkg::*;
(
    // Clock, reset and configuration
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic mode_async_i,
    input wire logic [CTF_LEN_W-1:0] field_len_i,
    // Link signals
    input wire logic vld,
    input wire logic [CTF_CHR_W-1:0] chr,
    input wire logic sof,
    input wire logic eof,
    input wire logic pad
);
    logic in_r, in_nxt, pd_r, pd_nxt;
    logic [CTF_LEN_W-1:0] n_r, n_nxt, cur;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);

    // Position of the current char within its field
    always_comb begin
        cur = sof ? 9'h001 : n_r + 9'h001;
        in_nxt = in_r;
        n_nxt = n_r;
        pd_nxt = pd_r;
        if (vld) begin
            in_nxt = !eof;
            n_nxt = cur;
            pd_nxt = pad && !eof;
        end
    end

    // Field tracking registers
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            in_r <= 1'b0;
            n_r <= CTF_LEN_RST;
            pd_r <= 1'b0;
        end else begin
            in_r <= in_nxt;
            n_r <= n_nxt;
            pd_r <= pd_nxt;
        end
    end

    // ------------------------------------------------------------
    // Link rules
    // ------------------------------------------------------------
    sof_first_a: assert property (vld && !in_r |-> sof)
        else $error("field opens without sof");
    sof_mid_a: assert property (vld && in_r |-> !sof)
        else $error("sof inside a field");
    idle_quiet_a: assert property (!vld |-> !(sof || eof || pad))
        else $error("marker without strobe");
    sync_len_a: assert property (vld && !mode_async_i |->
        eof == (cur == field_len_i))
        else $error("sync field length wrong");
    min_len_a: assert property (vld && eof |-> cur > CTF_OVERHEAD)
        else $error("field too short");
    max_len_a: assert property (vld |-> cur <= CTF_MAX_LEN)
        else $error("field too long");
    pad_tail_a: assert property (vld && pd_r |-> pad)
        else $error("packet char after padding");
    async_nopad_a: assert property (vld && mode_async_i |-> !pad)
        else $error("padding in async mode");

    // Main scenarios reached
    pad_end_c: cover property (vld && eof && pad);
    async_end_c: cover property (vld && eof && mode_async_i);
    full_len_c: cover property (vld && eof && cur == CTF_MAX_LEN);
endmodule : ctf_link_checker

// File: test/control_transport_field_framer_test.sv
// Self-checking bench for the framer and receiver pair
`timescale 1ns/10ps
module control_transport_field_framer_test;
    import ctf_pkg::*;
    logic sys_clk_i, rstn_i, mode_async_i, frame_tick_i, pkt_vld_i;
    logic [CTF_LEN_W-1:0] field_len_i, pkt_len_i;
    logic [CTF_CHR_W-1:0] pad_chr_i, pkt_chr_i, pkt_chr_o, base;
    logic pkt_rdy_o, busy_o, cfg_err_o, pkt_err_o, tick_miss_o;
    logic pkt_vld_o, pkt_first_o, field_done_o, field_err_o, pad_seen_o;
    logic [CTF_CHR_W-1:0] rx_q[$];
    int err_count, n_tests, pad_n;

    ctf_link_if lk ();
    ctf_framer u_ctf_framer (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
        .mode_async_i(mode_async_i), .field_len_i(field_len_i),
        .pad_chr_i(pad_chr_i), .frame_tick_i(frame_tick_i),
        .pkt_vld_i(pkt_vld_i), .pkt_chr_i(pkt_chr_i), .pkt_len_i(pkt_len_i),
        .pkt_rdy_o(pkt_rdy_o), .busy_o(busy_o), .cfg_err_o(cfg_err_o),
        .pkt_err_o(pkt_err_o), .tick_miss_o(tick_miss_o), .lk(lk));
    ctf_receiver u_ctf_receiver (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
        .mode_async_i(mode_async_i), .field_len_i(field_len_i), .lk(lk),
        .pkt_vld_o(pkt_vld_o), .pkt_first_o(pkt_first_o),
        .pkt_chr_o(pkt_chr_o), .field_done_o(field_done_o),
        .field_err_o(field_err_o), .pad_seen_o(pad_seen_o));
    ctf_link_checker u_ctf_link_checker (.sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i), .mode_async_i(mode_async_i),
        .field_len_i(field_len_i), .vld(lk.vld), .chr(lk.chr),
        .sof(lk.sof), .eof(lk.eof), .pad(lk.pad));

    // Clock source
    initial begin
        sys_clk_i = 1'b0;
        forever #25 sys_clk_i = ~sys_clk_i;
    end

    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : close_out

    // Collect receiver output and link padding
    always @(posedge sys_clk_i) begin
        if (pkt_vld_o) begin
            check({8'h00, pkt_first_o}, {8'h00, rx_q.size() == 0});
            rx_q.push_back(pkt_chr_o);
        end
        if (lk.vld && lk.pad) begin
            pad_n++;
            check({1'b0, lk.chr}, {1'b0, pad_chr_i});
        end
    end

    // One field: tick in sync mode, packet chars offered until taken
    task automatic field(input logic a, input logic [8:0] fl,
        input logic [8:0] pl, input logic bad, input logic [7:0] pd);
        int i, k;
        logic acc, perr, ferr, done, pseen;
        i = 0;
        perr = 1'b0;
        pseen = 1'b0;
        ferr = 1'b0;
        done = 1'b0;
        rx_q.delete();
        pad_n = 0;
        @(posedge sys_clk_i);
        mode_async_i <= a;
        field_len_i <= fl;
        pkt_len_i <= pl;
        pad_chr_i <= pd;
        pkt_chr_i <= base;
        pkt_vld_i <= (pl != 9'h000);
        frame_tick_i <= !a;
        @(posedge sys_clk_i);
        frame_tick_i <= 1'b0;
        for (k = 0; k < 700; k++) begin
            @(negedge sys_clk_i);
            acc = pkt_vld_i && pkt_rdy_o;
            perr |= pkt_err_o;
            pseen |= pad_seen_o;
            ferr |= field_err_o;
            done |= field_done_o;
            if (i == pl && !busy_o && (bad || done)) break;
            @(posedge sys_clk_i);
            if (acc) begin
                i++;
                pkt_chr_i <= base + i[7:0];
                if (i == pl) pkt_vld_i <= 1'b0;
            end
        end
        // Let the collector take the last receiver char
        @(negedge sys_clk_i);
        check(9'(rx_q.size()), bad ? 9'h000 : pl);
        check({8'h00, pseen}, 9'h000);
        check(9'(pad_n), (a || bad) ? 9'h000 : fl - pl);
        check({8'h00, perr}, {8'h00, bad});
        check({8'h00, ferr}, 9'h000);
        for (i = 0; i < rx_q.size(); i++) begin
            check({1'b0, rx_q[i]}, {1'b0, base + i[7:0]});
        end
        $display("field test done at %0t", $time);
        if (k == 700) begin
            err_count++;
            close_out();
        end
    endtask : field

    // Main sequence
    initial begin
        rstn_i = 1'b0;
        mode_async_i = 1'b0;
        frame_tick_i = 1'b0;
        pkt_vld_i = 1'b0;
        field_len_i = 9'h032;
        pkt_len_i = 9'h000;
        pad_chr_i = 8'hA5;
        pkt_chr_i = 8'h00;
        base = 8'h10;
        err_count = 0;
        n_tests = 0;
        pad_n = 0;
        repeat (12) @(posedge sys_clk_i);
        rstn_i <= 1'b1;
        field(1'b0, 9'h032, 9'h028, 1'b0, 8'hA5);
        field(1'b0, 9'h032, 9'h021, 1'b0, 8'hC3);
        field(1'b0, 9'h021, 9'h000, 1'b0, 8'h3C);
        field(1'b0, 9'h100, 9'h100, 1'b0, 8'h5A);
        field(1'b0, 9'h021, 9'h028, 1'b1, 8'hA5);
        field(1'b1, 9'h032, 9'h021, 1'b0, 8'hA5);
        field(1'b1, 9'h032, 9'h0C8, 1'b0, 8'hA5);
        field(1'b1, 9'h032, 9'h020, 1'b1, 8'hA5);
        // Tick held while a padding field runs is reported lost
        @(posedge sys_clk_i);
        mode_async_i <= 1'b0;
        field_len_i <= 9'h021;
        pkt_vld_i <= 1'b0;
        frame_tick_i <= 1'b1;
        repeat (3) @(posedge sys_clk_i);
        frame_tick_i <= 1'b0;
        @(negedge sys_clk_i);
        check({8'h00, tick_miss_o}, 9'h001);
        repeat (40) @(negedge sys_clk_i);
        check({8'h00, busy_o}, 9'h000);
        $display("tick test done at %0t", $time);
        @(posedge sys_clk_i);
        mode_async_i <= 1'b0;
        field_len_i <= 9'h020;
        frame_tick_i <= 1'b1;
        @(posedge sys_clk_i);
        frame_tick_i <= 1'b0;
        repeat (2) @(negedge sys_clk_i);
        check({8'h00, cfg_err_o}, 9'h001);
        check({8'h00, busy_o}, 9'h000);
        $display("config test done at %0t", $time);
        close_out();
    end
endmodule : control_transport_field_framer_test
